/* shared/adsq_map.vh */
// Register addresses, field positions, reset values and timing counts of the converter control
`ifndef ADSQ_MAP_VH
`define ADSQ_MAP_VH

// Register addresses (low 16 bits of the bus address)
`define ADSQ_RES_BASE    16'hff90
`define ADSQ_CSR_ADDR    16'hff98
`define ADSQ_TRG_ADDR    16'hff99
`define ADSQ_HALT_HI     16'hff3c
`define ADSQ_HALT_LO     16'hff3d

// Field positions of conversion_control_status
`define ADSQ_CSR_END     7
`define ADSQ_CSR_IE      6
`define ADSQ_CSR_START   5
`define ADSQ_CSR_SCAN    4
`define ADSQ_CSR_CKS     3
// Field positions of trigger_source_control and module_halt_control
`define ADSQ_TRG_HI      7
`define ADSQ_TRG_LO      6
`define ADSQ_HALT_BIT    9

// Reset values
`define ADSQ_CSR_RST     8'h00
`define ADSQ_TRG_RST     8'h3f
`define ADSQ_TRG_RSV     6'h3f
`define ADSQ_HALT_RST    16'h3fff
`define ADSQ_RES_RST     10'h000

// Trigger select codes
`define ADSQ_TRG_SW      2'b00
`define ADSQ_TRG_TMR     2'b01
`define ADSQ_TRG_EXT     2'b11

// One converter state is one clock cycle
`define ADSQ_STATE_CYC   1
// Phase lengths in states: start delay, sampling, per trial bit, tail
`define ADSQ_DLY0_ST     10
`define ADSQ_DLY1_ST     6
`define ADSQ_SPL0_ST     63
`define ADSQ_SPL1_ST     31
`define ADSQ_STEP0_ST    19
`define ADSQ_STEP1_ST    9
`define ADSQ_TAIL0_ST    2
`define ADSQ_TAIL1_ST    6
// Maximum conversion lengths in states
`define ADSQ_CONV0_MAX   266
`define ADSQ_CONV1_MAX   134
// Phase lengths in clock cycles
`define ADSQ_DLY0_CYC    (`ADSQ_DLY0_ST * `ADSQ_STATE_CYC)
`define ADSQ_DLY1_CYC    (`ADSQ_DLY1_ST * `ADSQ_STATE_CYC)
`define ADSQ_SPL0_CYC    (`ADSQ_SPL0_ST * `ADSQ_STATE_CYC)
`define ADSQ_SPL1_CYC    (`ADSQ_SPL1_ST * `ADSQ_STATE_CYC)
`define ADSQ_STEP0_CYC   (`ADSQ_STEP0_ST * `ADSQ_STATE_CYC)
`define ADSQ_STEP1_CYC   (`ADSQ_STEP1_ST * `ADSQ_STATE_CYC)
`define ADSQ_TAIL0_CYC   (`ADSQ_TAIL0_ST * `ADSQ_STATE_CYC)
`define ADSQ_TAIL1_CYC   (`ADSQ_TAIL1_ST * `ADSQ_STATE_CYC)

`endif

/* sim/adsq_ana_model.sv */
// Behavioural analog inputs and comparator facing the converter
`timescale 1ns/1ps
module adsq_ana_model (
   input  wire [79:0] lv_i,
   input  wire [2:0]  chan_i,
   input  wire [9:0]  trial_i,
   output wire        cmp_o
);
   // Ideal comparator; levels are held steady per channel so the search is exact
   assign cmp_o = lv_i[chan_i * 10 +: 10] >= trial_i;
endmodule // adsq_ana_model

/* sim/adsq_ctrl_sva.sv */
// Concurrent checks on the ports of the converter control block
`timescale 1ns/1ps
module adsq_ctrl_sva (
   input wire        clock_i,
   input wire        rst_n_i,
   input wire        hw_standby_i,
   input wire        sw_standby_i,
   input wire [15:0] bus_addr_i,
   input wire        bus_rd_i,
   input wire        bus_wr_i,
   input wire [7:0]  bus_rdata_o,
   input wire        sample_o,
   input wire [9:0]  trial_o,
   input wire        conv_done_irq_o,
   input wire        module_halted_o,
   input wire        res_valid_o,
   input wire        res_ready_i,
   input wire [9:0]  res_data_o,
   input wire [2:0]  res_chan_o
);
   logic [6:0] spl_cnt_r;
   // Length of the running sampling phase in cycles
   always_ff @(posedge clock_i or negedge rst_n_i)
      if (!rst_n_i) spl_cnt_r <= 7'h00;
      else spl_cnt_r <= sample_o ? spl_cnt_r + 7'h01 : 7'h00;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   a_halt_rd_zero: assert property (module_halted_o && bus_rd_i &&
      bus_addr_i[15:1] != 15'h7f9e |=> bus_rdata_o == 8'h00) else $error("read while halted");
   a_trg_low_ones: assert property (!module_halted_o && bus_rd_i &&
      bus_addr_i == 16'hff99 |=> bus_rdata_o[5:0] == 6'h3f) else $error("trigger low bits");
   a_res_low_zero: assert property (!module_halted_o && bus_rd_i &&
      bus_addr_i[15:3] == 13'h1ff2 && bus_addr_i[0] |=> bus_rdata_o[5:0] == 6'h00)
      else $error("result low bits");
   a_halt_bit_read: assert property (bus_rd_i && bus_addr_i == 16'hff3c
      |=> bus_rdata_o[1] == $past(module_halted_o)) else $error("halt bit readback");
   a_halt_quiet: assert property (module_halted_o [*2]
      |-> !sample_o && !conv_done_irq_o) else $error("activity while halted");
   a_sample_max: assert property (spl_cnt_r <= 7'd63) else $error("sampling too long");
   a_trial_first: assert property ($fell(sample_o) && (spl_cnt_r == 7'd63 ||
      spl_cnt_r == 7'd31) |-> ##[0:2] trial_o == 10'h200) else $error("first trial bit");
   // Flushes on halt, standby or a register write are excluded on purpose
   a_res_hold_stall: assert property (res_valid_o && !res_ready_i && !module_halted_o &&
      !bus_wr_i && !$past(bus_wr_i) && !hw_standby_i && !sw_standby_i
      |=> res_valid_o && $stable(res_data_o) && $stable(res_chan_o)) else $error("result lost");
   c_stall: cover property (res_valid_o && !res_ready_i);
   c_irq: cover property ($rose(conv_done_irq_o));
   c_sample_end: cover property ($fell(sample_o));
endmodule // adsq_ctrl_sva

/* sim/testbench.sv */
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module testbench;
   logic        clock_i = 1'b0, rst_n_i = 1'b0, hw_standby_i = 1'b0, sw_standby_i = 1'b0;
   logic        bus_rd_i = 1'b0, bus_wr_i = 1'b0, tmr_trig_i = 1'b0, ext_trigger_pin_i = 1'b1;
   logic        res_ready_i = 1'b0, sample_o, cmp_i, conv_done_irq_o, module_halted_o, res_valid_o;
   logic [15:0] bus_addr_i = 16'h0000;
   logic [7:0]  bus_wdata_i = 8'h00, bus_rdata_o;
   logic [9:0]  trial_o, res_data_o, lv [0:7];
   logic [2:0]  chan_sel_o, res_chan_o;
   logic [31:0] seed = 32'hf840;
   int          err_total = 0, cmp_count = 0, exp_ch = 0, first = 0, last = 0, stall = 0;
   adsq_ctrl adsq_ctrl_i (.clock_i, .rst_n_i, .hw_standby_i, .sw_standby_i, .bus_addr_i,
      .bus_rd_i, .bus_wr_i, .bus_wdata_i, .bus_rdata_o, .tmr_trig_i, .ext_trigger_pin_i,
      .sample_o, .trial_o, .chan_sel_o, .cmp_i, .conv_done_irq_o, .module_halted_o,
      .res_valid_o, .res_ready_i, .res_data_o, .res_chan_o);
   adsq_ana_model adsq_ana_model_i (.lv_i({lv[7], lv[6], lv[5], lv[4], lv[3], lv[2], lv[1],
      lv[0]}), .chan_i(chan_sel_o), .trial_i(trial_o), .cmp_o(cmp_i));
   always #2 clock_i = ~clock_i;
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input string n, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clock_i);
      bus_addr_i <= a;
      bus_wdata_i <= v;
      bus_wr_i <= 1'b1;
      @(posedge clock_i);
      bus_wr_i <= 1'b0;
   endtask
   // Read data is registered, so it is taken one cycle after the strobe
   task rd(input logic [15:0] a, input logic [7:0] e, input string n);
      @(posedge clock_i);
      bus_addr_i <= a;
      bus_rd_i <= 1'b1;
      @(posedge clock_i);
      bus_rd_i <= 1'b0;
      @(negedge clock_i);
      chk(n, bus_rdata_o, e);
   endtask
   task kick(input logic t, input logic p);
      @(posedge clock_i);
      tmr_trig_i <= t;
      ext_trigger_pin_i <= !p;
      repeat (4) @(posedge clock_i);
      tmr_trig_i <= 1'b0;
      ext_trigger_pin_i <= 1'b1;
   endtask
   // Polled off the edge; the limit is the longest wait the rules allow for a single conversion, a looser one for scans
   task wirq(input int lim);
      for (int n = 0; n < lim && conv_done_irq_o !== 1'b1; n++) @(negedge clock_i);
      chk("irq", conv_done_irq_o, 1'b1);
   endtask
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Result consumer with random stalls; every word is checked in order
   always @(posedge clock_i) begin
      res_ready_i <= stall == 0 && xs() % 3 != 0;
      if (rst_n_i && res_valid_o && res_ready_i) begin
         chk("res_chan", res_chan_o, exp_ch);
         chk("res_data", res_data_o, lv[res_chan_o]);
         exp_ch = exp_ch == last ? first : exp_ch + 1;
      end
   end
   initial begin
      #240000;
      err_total++;
      close_out;
   end
   initial begin
      for (int k = 0; k < 8; k++) lv[k] = 10'h000;
      repeat (12) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(16'hff3c, 8'h3f, "halt_hi");
      rd(16'hff99, 8'h00, "trg_halted");
      wr(16'hff3c, 8'h3d);
      rd(16'hff3d, 8'hff, "halt_lo");
      rd(16'hff98, 8'h00, "csr_rst");
      rd(16'hff99, 8'h3f, "trg_rst");
      rd(16'hff9a, 8'h00, "unmapped");
      wr(16'hff99, 8'h80);
      kick(1'b1, 1'b1);
      rd(16'hff99, 8'hbf, "trg_rw");
      rd(16'hff98, 8'h00, "no_start");
      // One single conversion per channel; the last two start from timer and pin
      for (int i = 0; i < 8; i++) begin
         logic [1:0] tg;
         tg = i == 6 ? 2'b01 : i == 7 ? 2'b11 : 2'b00;
         lv[i] = 10'(xs());
         first = i;
         last = i;
         exp_ch = i;
         wr(16'hff99, {tg, 6'h00});
         wr(16'hff98, {2'b01, tg == 2'b00, 1'b0, i[0], 3'(i)});
         kick(tg == 2'b01, tg == 2'b11);
         wirq(i[0] ? 134 : 266);
         wr(16'hff98, {2'b01, 2'b00, i[0], 3'(i)});
         rd(16'hff98, {2'b11, 2'b00, i[0], 3'(i)}, "csr_done");
         rd({13'h1ff2, i[1:0], 1'b0}, lv[i][9:2], "res_hi");
         rd({13'h1ff2, i[1:0], 1'b1}, {lv[i][1:0], 6'h00}, "res_lo");
         wr(16'hff98, 8'h80);
         rd(16'hff98, 8'h80, "flag_kept");
         wr(16'hff98, 8'h00);
         rd(16'hff98, 8'h00, "flag_clr");
      end
      // Scan of the upper group with the consumer stalled until the buffer refuses
      for (int k = 4; k < 7; k++) lv[k] = 10'(xs());
      first = 4;
      last = 6;
      exp_ch = 4;
      stall = 1;
      wr(16'hff99, 8'h00);
      wr(16'hff98, 8'h76);
      repeat (1500) @(posedge clock_i);
      chk("buf_full", res_valid_o, 1'b1);
      chk("stalled", sample_o, 1'b0);
      stall = 0;
      wirq(3000);
      rd(16'hff98, 8'hf6, "scan_run");
      for (int k = 0; k < 3; k++) rd({13'h1ff2, 2'(k), 1'b0}, lv[k + 4][9:2], "scan_res");
      wr(16'hff98, 8'h56);
      repeat (40) @(posedge clock_i);
      chk("irq_clr", conv_done_irq_o, 1'b0);
      exp_ch = 4;
      wr(16'hff98, 8'h76);
      wirq(3000);
      // Halt in mid-scan, then both standby kinds
      wr(16'hff3c, 8'h3f);
      rd(16'hff98, 8'h00, "csr_halted");
      chk("halted", module_halted_o, 1'b1);
      wr(16'hff3c, 8'h3d);
      rd(16'hff98, 8'h00, "csr_reinit");
      wr(16'hff99, 8'h40);
      sw_standby_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      sw_standby_i <= 1'b0;
      rd(16'hff3c, 8'h3d, "halt_kept");
      rd(16'hff99, 8'h3f, "trg_sby");
      @(posedge clock_i);
      hw_standby_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      hw_standby_i <= 1'b0;
      rd(16'hff3c, 8'h3f, "halt_hw");
      close_out;
   end
endmodule // testbench
bind adsq_ctrl adsq_ctrl_sva adsq_ctrl_sva_i (.clock_i, .rst_n_i, .hw_standby_i, .sw_standby_i,
   .bus_addr_i, .bus_rd_i, .bus_wr_i, .bus_rdata_o, .sample_o, .trial_o, .conv_done_irq_o,
   .module_halted_o, .res_valid_o, .res_ready_i, .res_data_o, .res_chan_o);

/* src/adsq_buf2.v */
// Two-entry valid/ready buffer for conversion results
`timescale 1ns/1ps
module adsq_buf2 #(
   parameter W = 13
) (
   input  wire         clock_i,
   input  wire         rst_n_i,
   input  wire         flush_i,
   input  wire         in_valid_i,
   output wire         in_ready_o,
   input  wire [W-1:0] in_data_i,
   output wire         out_valid_o,
   input  wire         out_ready_i,
   output wire [W-1:0] out_data_o
);
   reg [W-1:0] ent0_r;
   reg [W-1:0] ent1_r;
   reg [1:0]   cnt_r;
   wire        push;
   wire        pop;

   // Full at two entries so the producer sees back-pressure
   assign in_ready_o  = (cnt_r != 2'd2);
   assign out_valid_o = (cnt_r != 2'd0);
   assign out_data_o  = ent0_r;            // Head comes straight from a flop
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   // Entry 0 is the head; entry 1 shifts down on a pop
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ent0_r <= {W{1'b0}};
         ent1_r <= {W{1'b0}};
         cnt_r  <= 2'd0;
      end else if (flush_i) begin
         cnt_r <= 2'd0;
      end else begin
         if (pop) begin
            ent0_r <= (cnt_r == 2'd2) ? ent1_r : in_data_i;
            if (push && cnt_r == 2'd2)
               ent1_r <= in_data_i;
         end else if (push) begin
            if (cnt_r == 2'd0)
               ent0_r <= in_data_i;
            else
               ent1_r <= in_data_i;
         end
         if (push && !pop)
            cnt_r <= cnt_r + 2'd1;
         else if (pop && !push)
            cnt_r <= cnt_r - 2'd1;
      end
   end
endmodule // adsq_buf2

/* src/adsq_ctrl.v */
// Sequencer and register file of the 10-bit successive-approximation converter
//
// Behaviour
// - Start bit set by software, timer trigger or external pin; held during conversion.
// - Single mode clears the start bit when the one channel finishes.
// - Scan mode repeats until start cleared by software, reset, standby or halt.
// - Status bit 4 selects single (0, reset) or scan (1) mode.
// - Time select 0 gives at most 266 states, 1 gives at most 134.
// - Top channel bit picks group; low bits pick channel or last scan channel.
// - Trigger code 00 software only, 01 timer, 11 external pin, 10 no hardware trigger.
// - Six low trigger register bits read 1 and ignore writes.
// - Trigger register initialised on reset, standby and module halt.
// - Halt bit 9 stops the converter after the bus cycle and blocks access.
// - Halt register initialised on reset and hardware standby, kept in software standby.
// - Upper result byte read also copies the lower byte into the holding latch.
// - Lower result byte read returns the holding latch.
// - Ten-bit successive approximation, single and scan modes only.
// - Single-mode completion stores result, sets end flag, clears start, idles together.
// - Interrupt request while end flag and interrupt enable are both 1.
// - End flag cleared only by writing 0 after reading it as 1, or by reset, standby or halt.
// - Scan starts at group's first channel, next channel follows after one wait cycle once the buffer has room.
// - Scan sets end flag after the last channel, then restarts at the first.
// - Scan restarted after a stop begins at the group's first channel.
// - Result upper 8 bits in 15..8, low 2 bits in 7..6, rest zero.
// - Channels n and n+4 share result register A, B, C or D.
// - Writing 1 to the end flag has no effect.
`include "adsq_map.vh"
`timescale 1ns/1ps
module adsq_ctrl (
   input  wire        clock_i,
   input  wire        rst_n_i,
   input  wire        hw_standby_i,
   input  wire        sw_standby_i,
   input  wire [15:0] bus_addr_i,
   input  wire        bus_rd_i,
   input  wire        bus_wr_i,
   input  wire [7:0]  bus_wdata_i,
   output wire [7:0]  bus_rdata_o,
   input  wire        tmr_trig_i,
   input  wire        ext_trigger_pin_i,
   output wire        sample_o,
   output wire [9:0]  trial_o,
   output wire [2:0]  chan_sel_o,
   input  wire        cmp_i,
   output wire        conv_done_irq_o,
   output wire        module_halted_o,
   output wire        res_valid_o,
   input  wire        res_ready_i,
   output wire [9:0]  res_data_o,
   output wire [2:0]  res_chan_o
);
   localparam S_IDLE   = 3'd0;
   localparam S_DELAY  = 3'd1;
   localparam S_SAMPLE = 3'd2;
   localparam S_BIT    = 3'd3;
   localparam S_TAIL   = 3'd4;
   localparam S_WAIT   = 3'd5;

   localparam [8:0] DLY0  = `ADSQ_DLY0_CYC - 1;
   localparam [8:0] DLY1  = `ADSQ_DLY1_CYC - 1;
   localparam [8:0] SPL0  = `ADSQ_SPL0_CYC - 1;
   localparam [8:0] SPL1  = `ADSQ_SPL1_CYC - 1;
   localparam [8:0] STEP0 = `ADSQ_STEP0_CYC - 1;
   localparam [8:0] STEP1 = `ADSQ_STEP1_CYC - 1;
   localparam [8:0] TAIL0 = `ADSQ_TAIL0_CYC - 1;
   localparam [8:0] TAIL1 = `ADSQ_TAIL1_CYC - 1;
   localparam [15:0] RES_BASE = `ADSQ_RES_BASE;

   // Control/status fields
   reg        end_flag_r;
   reg        irq_en_r;
   reg        start_r;
   reg        scan_r;
   reg        cks_r;
   reg [2:0]  chsel_r;
   reg        armed_r;
   reg [1:0]  trg_sel_r;
   reg [15:0] halt_r;
   // Results and holding latch
   reg [9:0]  res_a_r;
   reg [9:0]  res_b_r;
   reg [9:0]  res_c_r;
   reg [9:0]  res_d_r;
   reg [7:0]  hold_r;
   reg [7:0]  rdata_r;
   // Sequencer
   reg [2:0]  state_r;
   reg [8:0]  cnt_r;
   reg [3:0]  bit_r;
   reg [9:0]  sar_r;
   reg [1:0]  chan_r;
   // Trigger pin synchroniser
   reg        ext_m_r;
   reg        ext_s_r;
   reg        ext_d_r;

   wire       halted   = halt_r[`ADSQ_HALT_BIT];
   wire       clr_conv = halted | hw_standby_i | sw_standby_i;
   wire       buf_rdy;
   wire       cnt_done = (cnt_r == 9'd0);
   wire       conv_end = (state_r == S_TAIL) && cnt_done && start_r;
   wire       last_ch  = (chan_r == chsel_r[1:0]);
   wire       done_set = conv_end && (!scan_r || last_ch);
   wire       acc      = !halted;
   wire       wr_csr   = bus_wr_i && acc && (bus_addr_i == `ADSQ_CSR_ADDR);
   wire       wr_trg   = bus_wr_i && acc && (bus_addr_i == `ADSQ_TRG_ADDR);
   wire       rd_csr   = bus_rd_i && acc && (bus_addr_i == `ADSQ_CSR_ADDR);
   wire       res_hit  = (bus_addr_i[15:3] == RES_BASE[15:3]);
   wire       ext_fall = ext_d_r & ~ext_s_r;
   wire [9:0] res_sel;
   wire [7:0] csr_val;
   wire       trig;
   wire [1:0] grp_ch;

   // Group bit goes out unchanged; low bits walk in scan, fixed in single
   assign grp_ch     = scan_r ? chan_r : chsel_r[1:0];
   assign chan_sel_o = {chsel_r[2], grp_ch};
   assign sample_o   = (state_r == S_SAMPLE);
   assign trial_o    = sar_r;
   assign conv_done_irq_o = end_flag_r & irq_en_r;
   assign module_halted_o = halted;
   assign bus_rdata_o = rdata_r;
   assign csr_val = {end_flag_r, irq_en_r, start_r, scan_r, cks_r, chsel_r};

   // Only the selected hardware trigger source may start a conversion; a software write starts one under any code
   assign trig = ((trg_sel_r == `ADSQ_TRG_TMR) && tmr_trig_i) ||
                 ((trg_sel_r == `ADSQ_TRG_EXT) && ext_fall);

   // Channels n and n+4 share one result register
   assign res_sel = (bus_addr_i[2:1] == 2'd0) ? res_a_r :
                    (bus_addr_i[2:1] == 2'd1) ? res_b_r :
                    (bus_addr_i[2:1] == 2'd2) ? res_c_r : res_d_r;

   // Two flops before the edge detector; the first is read by nothing else
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ext_m_r <= 1'b1;
         ext_s_r <= 1'b1;
         ext_d_r <= 1'b1;
      end else begin
         ext_m_r <= ext_trigger_pin_i;
         ext_s_r <= ext_m_r;
         ext_d_r <= ext_s_r;
      end
   end

   // Halt register survives software standby, reloads on hardware standby
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i)
         halt_r <= `ADSQ_HALT_RST;
      else if (hw_standby_i)
         halt_r <= `ADSQ_HALT_RST;
      else if (bus_wr_i && bus_addr_i == `ADSQ_HALT_HI)
         halt_r[15:8] <= bus_wdata_i;
      else if (bus_wr_i && bus_addr_i == `ADSQ_HALT_LO)
         halt_r[7:0] <= bus_wdata_i;
   end

   // Control/status and trigger registers
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         end_flag_r <= 1'b0;
         irq_en_r   <= 1'b0;
         start_r    <= 1'b0;
         scan_r     <= 1'b0;
         cks_r      <= 1'b0;
         chsel_r    <= 3'd0;
         armed_r    <= 1'b0;
         trg_sel_r  <= `ADSQ_TRG_SW;
      end else if (clr_conv) begin
         // Halt or standby ends conversion and reinitialises the setup
         end_flag_r <= 1'b0;
         irq_en_r   <= 1'b0;
         start_r    <= 1'b0;
         scan_r     <= 1'b0;
         cks_r      <= 1'b0;
         chsel_r    <= 3'd0;
         armed_r    <= 1'b0;
         trg_sel_r  <= `ADSQ_TRG_SW;
      end else begin
         if (rd_csr && end_flag_r)
            armed_r <= 1'b1;
         if (wr_csr) begin
            irq_en_r <= bus_wdata_i[`ADSQ_CSR_IE];
            scan_r   <= bus_wdata_i[`ADSQ_CSR_SCAN];
            cks_r    <= bus_wdata_i[`ADSQ_CSR_CKS];
            chsel_r  <= bus_wdata_i[2:0];
            armed_r  <= 1'b0;
         end
         // Only a written 0 after an armed read clears; a 1 is ignored
         if (wr_csr && armed_r && !bus_wdata_i[`ADSQ_CSR_END])
            end_flag_r <= 1'b0;
         // Set wins over a clear in the same cycle
         if (done_set)
            end_flag_r <= 1'b1;
         // Start bit: completion clear, then software, then trigger set
         if (conv_end && !scan_r)
            start_r <= 1'b0;
         if (wr_csr)
            start_r <= bus_wdata_i[`ADSQ_CSR_START];
         if (trig)
            start_r <= 1'b1;
         if (wr_trg)
            trg_sel_r <= bus_wdata_i[7:6];
      end
   end

   // Sequencer: delay, sample, ten trial bits, tail; scan loops without delay
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= S_IDLE;
         cnt_r   <= 9'd0;
         bit_r   <= 4'd0;
         sar_r   <= 10'd0;
         chan_r  <= 2'd0;
      end else if (clr_conv || (state_r != S_IDLE && !start_r)) begin
         state_r <= S_IDLE;
         chan_r  <= 2'd0;
         sar_r   <= 10'd0;
      end else begin
         case (state_r)
            S_IDLE: begin
               // Waiting for buffer room means a finished word is never lost
               if (start_r && buf_rdy) begin
                  state_r <= S_DELAY;
                  cnt_r   <= cks_r ? DLY1 : DLY0;
                  chan_r  <= 2'd0;
               end
            end
            S_DELAY: begin
               if (cnt_done) begin
                  state_r <= S_SAMPLE;
                  cnt_r   <= cks_r ? SPL1 : SPL0;
               end else
                  cnt_r <= cnt_r - 9'd1;
            end
            S_SAMPLE: begin
               if (cnt_done) begin
                  state_r <= S_BIT;
                  bit_r   <= 4'd9;
                  sar_r   <= 10'h200;
                  cnt_r   <= cks_r ? STEP1 : STEP0;
               end else
                  cnt_r <= cnt_r - 9'd1;
            end
            S_BIT: begin
               if (cnt_done) begin
                  // Comparator low means the trial overshot: drop the bit
                  sar_r[bit_r] <= cmp_i;
                  if (bit_r == 4'd0) begin
                     state_r <= S_TAIL;
                     cnt_r   <= cks_r ? TAIL1 : TAIL0;
                  end else begin
                     sar_r[bit_r - 4'd1] <= 1'b1;
                     bit_r <= bit_r - 4'd1;
                     cnt_r <= cks_r ? STEP1 : STEP0;
                  end
               end else
                  cnt_r <= cnt_r - 9'd1;
            end
            S_TAIL: begin
               if (cnt_done) begin
                  if (!scan_r)
                     state_r <= S_IDLE;
                  else begin
                     state_r <= S_WAIT;
                     chan_r  <= last_ch ? 2'd0 : chan_r + 2'd1;
                  end
               end else
                  cnt_r <= cnt_r - 9'd1;
            end
            S_WAIT: begin
               // One cycle gap lets the buffer show room before the next word
               if (buf_rdy) begin
                  state_r <= S_SAMPLE;
                  cnt_r   <= cks_r ? SPL1 : SPL0;
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   // Results land in the register of the converted channel
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         res_a_r <= `ADSQ_RES_RST;
         res_b_r <= `ADSQ_RES_RST;
         res_c_r <= `ADSQ_RES_RST;
         res_d_r <= `ADSQ_RES_RST;
      end else if (clr_conv) begin
         res_a_r <= `ADSQ_RES_RST;
         res_b_r <= `ADSQ_RES_RST;
         res_c_r <= `ADSQ_RES_RST;
         res_d_r <= `ADSQ_RES_RST;
      end else if (conv_end) begin
         if (grp_ch == 2'd0)
            res_a_r <= sar_r;
         else if (grp_ch == 2'd1)
            res_b_r <= sar_r;
         else if (grp_ch == 2'd2)
            res_c_r <= sar_r;
         else
            res_d_r <= sar_r;
      end
   end

   // Read data and holding latch; reads while halted see zero except the halt register
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_r <= 8'h00;
         hold_r  <= 8'h00;
      end else begin
         if (clr_conv)
            hold_r <= 8'h00;
         if (!bus_rd_i)
            rdata_r <= 8'h00;
         else if (bus_addr_i == `ADSQ_HALT_HI)
            rdata_r <= halt_r[15:8];
         else if (bus_addr_i == `ADSQ_HALT_LO)
            rdata_r <= halt_r[7:0];
         else if (!acc)
            rdata_r <= 8'h00;
         else if (bus_addr_i == `ADSQ_CSR_ADDR)
            rdata_r <= csr_val;
         else if (bus_addr_i == `ADSQ_TRG_ADDR)
            rdata_r <= {trg_sel_r, `ADSQ_TRG_RSV};
         else if (res_hit && !bus_addr_i[0]) begin
            rdata_r <= res_sel[9:2];
            if (!clr_conv)
               hold_r <= {res_sel[1:0], 6'h00};
         end else if (res_hit)
            rdata_r <= hold_r;
         else
            rdata_r <= 8'h00;
      end
   end

   // Finished words also leave through a small buffer to a stream consumer
   adsq_buf2 #(
      .W (13)
   ) u_buf (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (clr_conv),
      .in_valid_i  (conv_end),
      .in_ready_o  (buf_rdy),
      .in_data_i   ({chsel_r[2], grp_ch, sar_r}),
      .out_valid_o (res_valid_o),
      .out_ready_i (res_ready_i),
      .out_data_o  ({res_chan_o, res_data_o})
   );
endmodule // adsq_ctrl
